// >>> hdl/timer_cc_pkg.sv
// constants shared by the timer capture/compare register ends
// assumes an 8-bit I/O bus with 6-bit I/O addresses
package timer_cc_pkg;

    // bus geometry
    localparam int unsigned IO_ADDR_W = 6;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CMD_ADDR_W = 7;
    localparam int unsigned IRQ_NUM = 4;

    // i/o offsets
    localparam logic [5:0] CAPTURE_LOW_OFS = 6'h26;
    localparam logic [5:0] CAPTURE_HIGH_OFS = 6'h27;
    localparam logic [5:0] COMPARE_B_LOW_OFS = 6'h28;
    localparam logic [5:0] COMPARE_B_HIGH_OFS = 6'h29;
    localparam logic [5:0] COMPARE_A_HIGH_OFS = 6'h2B;
    localparam logic [5:0] COUNTER_LOW_OFS = 6'h2C;
    localparam logic [5:0] COUNTER_HIGH_OFS = 6'h2D;
    localparam logic [5:0] IRQ_FLAGS_OFS = 6'h38;
    localparam logic [5:0] IRQ_ENABLES_OFS = 6'h39;

    // address spaces
    localparam logic [6:0] IO_SPACE_TOP = 7'h3F;
    localparam logic [6:0] DATA_SPACE_BASE = 7'h20;
    localparam logic [6:0] DATA_SPACE_TOP = 7'h5F;

    // bit positions in flag and enable registers; source i sits at IRQ_BIT_LO + i
    localparam int unsigned CAPTURE_BIT = 5;
    localparam int unsigned COMPARE_A_BIT = 4;
    localparam int unsigned COMPARE_B_BIT = 3;
    localparam int unsigned OVERFLOW_BIT = 2;
    localparam int unsigned IRQ_BIT_LO = 2;

    // reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [3:0] IRQ_RESET = 4'h0;

    // waveform modes that take the capture register as top
    localparam logic [3:0] MODE_PFC_CAPTURE_TOP = 4'h8;
    localparam logic [3:0] MODE_PC_CAPTURE_TOP = 4'hA;
    localparam logic [3:0] MODE_CTC_CAPTURE_TOP = 4'hC;
    localparam logic [3:0] MODE_FAST_CAPTURE_TOP = 4'hE;

endpackage : timer_cc_pkg

// >>> hdl/timer_io_if.sv
// i/o bus and interrupt lines between the cpu end and the timer register end
// assumes both ends share core_clk; the bench drives nothing through it
`timescale 1ns/100ps
interface timer_io_if;
    import timer_cc_pkg::*;

    logic [IO_ADDR_W-1:0] io_addr;
    logic [DATA_W-1:0] io_wdata;
    logic io_wr;
    logic io_rd;
    logic [DATA_W-1:0] io_rdata;
    logic global_irq_en;
    logic [IRQ_NUM-1:0] irq_req;
    logic [IRQ_NUM-1:0] irq_ack;

    modport device (
        input io_addr,
        input io_wdata,
        input io_wr,
        input io_rd,
        output io_rdata,
        input global_irq_en,
        output irq_req,
        input irq_ack
    );

    modport cpu (
        output io_addr,
        output io_wdata,
        output io_wr,
        output io_rd,
        input io_rdata,
        output global_irq_en,
        input irq_req,
        output irq_ack
    );

endinterface : timer_io_if

// >>> hdl/sync2.sv
// two-flop synchroniser for asynchronous level inputs
// assumes inputs are levels wider than a clock period
`timescale 1ns/100ps
module sync2 #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : sync2

// >>> hdl/timer_capture_compare.sv
// capture register, compare-b register, shared high-byte latch and
// interrupt flag/enable logic of a 16-bit timer
// assumes counter, compare-a and prescaler live in neighbour blocks on core_clk
`timescale 1ns/100ps

module timer_capture_compare
    import timer_cc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // i/o bus and interrupt lines
    timer_io_if.device bus,
    // counter unit
    input wire logic [15:0] counter_value,
    input wire logic [15:0] compare_a_value,
    input wire logic timer_tick,
    input wire logic top_reached,
    input wire logic overflow_event,
    input wire logic [3:0] waveform_mode_sel,
    input wire logic force_compare_b,
    // capture source controls
    input wire logic capture_rising,
    input wire logic capture_from_comp,
    // asynchronous inputs
    input wire logic capture_pin,
    input wire logic analog_comp_out,
    // results
    output logic [15:0] capture_value,
    output logic [15:0] compare_b_value,
    output logic [7:0] shared_temp,
    output logic compare_b_event,
    output logic capture_is_top
);

    logic [1:0] pin_sync;
    logic src_now;
    logic src_prev_reg;
    logic cap_edge;
    logic pin_event;
    logic top_event;
    logic a_hit_reg;
    logic b_hit_reg;
    logic [3:0] flag_set;
    logic [3:0] flag_clr;
    logic [3:0] flags_reg;
    logic [3:0] flags_next;
    logic [3:0] enables_reg;
    logic [7:0] rdata_next;
    logic wr_capture_low;
    logic wr_compare_b_low;

    // pin and comparator are asynchronous; comparator glitches are filtered by the sync only
    sync2 #(
        .WIDTH(2)
    ) u_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .async_in({analog_comp_out, capture_pin}),
        .sync_out(pin_sync)
    );

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            capture_is_top <= 1'b0;
        end else begin
            capture_is_top <= (waveform_mode_sel == MODE_PFC_CAPTURE_TOP) ||
                (waveform_mode_sel == MODE_PC_CAPTURE_TOP) ||
                (waveform_mode_sel == MODE_CTC_CAPTURE_TOP) ||
                (waveform_mode_sel == MODE_FAST_CAPTURE_TOP);
        end
    end

    // edge detection on the selected capture source
    assign src_now = capture_from_comp ? pin_sync[1] : pin_sync[0];
    assign cap_edge = capture_rising ? (src_now & ~src_prev_reg) : (~src_now & src_prev_reg);
    assign pin_event = cap_edge & ~capture_is_top;
    assign top_event = capture_is_top & top_reached & timer_tick;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            src_prev_reg <= 1'b0;
        end else begin
            src_prev_reg <= src_now;
        end
    end

    assign wr_capture_low = bus.io_wr && (bus.io_addr == CAPTURE_LOW_OFS);
    assign wr_compare_b_low = bus.io_wr && (bus.io_addr == COMPARE_B_LOW_OFS);

    // capture register; a capture beats a same-cycle software write
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            capture_value <= WORD_RESET;
        end else if (pin_event) begin
            capture_value <= counter_value;
        end else if (wr_capture_low) begin
            capture_value <= {shared_temp, bus.io_wdata};
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            compare_b_value <= WORD_RESET;
        end else if (wr_compare_b_low) begin
            compare_b_value <= {shared_temp, bus.io_wdata};
        end
    end

    // one latch for every 16-bit register of the timer, including the neighbours'
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            shared_temp <= BYTE_RESET;
        end else if (bus.io_wr && ((bus.io_addr == CAPTURE_HIGH_OFS) ||
                (bus.io_addr == COMPARE_B_HIGH_OFS) ||
                (bus.io_addr == COMPARE_A_HIGH_OFS) ||
                (bus.io_addr == COUNTER_HIGH_OFS))) begin
            shared_temp <= bus.io_wdata;
        end else if (bus.io_rd && (bus.io_addr == CAPTURE_LOW_OFS)) begin
            shared_temp <= capture_value[15:8];
        end else if (bus.io_rd && (bus.io_addr == COUNTER_LOW_OFS)) begin
            shared_temp <= counter_value[15:8];
        end
    end

    // compare hits are registered so the flag lands one cycle after the matching tick
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            a_hit_reg <= 1'b0;
            b_hit_reg <= 1'b0;
        end else begin
            a_hit_reg <= timer_tick && (counter_value == compare_a_value);
            b_hit_reg <= timer_tick && (counter_value == compare_b_value);
        end
    end

    // the waveform unit sees forced strobes, the flags never do
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            compare_b_event <= 1'b0;
        end else begin
            compare_b_event <= (timer_tick && (counter_value == compare_b_value)) || force_compare_b;
        end
    end

    // index i of the four-bit vectors is flag bit IRQ_BIT_LO + i
    always_comb begin
        flag_set = 4'h0;
        flag_set[CAPTURE_BIT-IRQ_BIT_LO] = pin_event | top_event;
        flag_set[COMPARE_A_BIT-IRQ_BIT_LO] = a_hit_reg;
        flag_set[COMPARE_B_BIT-IRQ_BIT_LO] = b_hit_reg;
        flag_set[OVERFLOW_BIT-IRQ_BIT_LO] = overflow_event;
    end

    always_comb begin
        flag_clr = bus.irq_ack;
        if (bus.io_wr && (bus.io_addr == IRQ_FLAGS_OFS)) begin
            flag_clr = flag_clr | bus.io_wdata[IRQ_BIT_LO +: IRQ_NUM];
        end
    end

    // a new event wins over a clear in the same cycle
    assign flags_next = (flags_reg & ~flag_clr) | flag_set;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_reg <= IRQ_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            enables_reg <= IRQ_RESET;
        end else if (bus.io_wr && (bus.io_addr == IRQ_ENABLES_OFS)) begin
            enables_reg <= bus.io_wdata[IRQ_BIT_LO +: IRQ_NUM];
        end
    end

    // one request line per source
    generate
        for (genvar i = 0; i < IRQ_NUM; i++) begin : g_irq
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    bus.irq_req[i] <= 1'b0;
                end else begin
                    bus.irq_req[i] <= flags_reg[i] & enables_reg[i] & bus.global_irq_en;
                end
            end
        end
    endgenerate

    // read mux; bits owned by other timers and unmapped offsets read zero
    always_comb begin
        rdata_next = 8'h00;
        case (bus.io_addr)
            CAPTURE_LOW_OFS: rdata_next = capture_value[7:0];
            CAPTURE_HIGH_OFS: rdata_next = shared_temp;
            COMPARE_B_LOW_OFS: rdata_next = compare_b_value[7:0];
            COMPARE_B_HIGH_OFS: rdata_next = compare_b_value[15:8];
            IRQ_FLAGS_OFS: rdata_next[IRQ_BIT_LO +: IRQ_NUM] = flags_reg;
            IRQ_ENABLES_OFS: rdata_next[IRQ_BIT_LO +: IRQ_NUM] = enables_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus.io_rdata <= BYTE_RESET;
        end else if (bus.io_rd) begin
            bus.io_rdata <= rdata_next;
        end
    end

endmodule : timer_capture_compare

// >>> hdl/timer_cpu_end.sv
// cpu end: turns software commands into i/o bus cycles and forwards interrupts
// assumes software commands arrive on core_clk from same-domain logic
`timescale 1ns/100ps
module timer_cpu_end
    import timer_cc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // i/o bus and interrupt lines
    timer_io_if.cpu bus,
    // software command port
    input wire logic [CMD_ADDR_W-1:0] cmd_addr,
    input wire logic cmd_data_space,
    input wire logic [DATA_W-1:0] cmd_wdata,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    output logic [DATA_W-1:0] cmd_rdata,
    output logic cmd_rvalid,
    // interrupt controller side
    input wire logic global_irq_en,
    input wire logic [IRQ_NUM-1:0] vector_ack,
    output logic [IRQ_NUM-1:0] irq_pending
);

    logic addr_ok;
    logic [CMD_ADDR_W-1:0] io_addr_next;
    logic rd_any_reg;
    logic rd_wait_reg;
    logic rd_ok_reg;
    logic rd_ok_wait_reg;

    // data space sits 0x20 above the i/o offsets; anything outside is dropped
    always_comb begin
        if (cmd_data_space) begin
            addr_ok = (cmd_addr >= DATA_SPACE_BASE) && (cmd_addr <= DATA_SPACE_TOP);
            io_addr_next = cmd_addr - DATA_SPACE_BASE;
        end else begin
            addr_ok = cmd_addr <= IO_SPACE_TOP;
            io_addr_next = cmd_addr;
        end
    end

    // software reads the capture and counter values low byte first so the high byte comes from the latch
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus.io_addr <= '0;
            bus.io_wdata <= BYTE_RESET;
            bus.io_wr <= 1'b0;
            bus.io_rd <= 1'b0;
        end else begin
            bus.io_addr <= io_addr_next[IO_ADDR_W-1:0];
            bus.io_wdata <= cmd_wdata;
            bus.io_wr <= cmd_wr && addr_ok;
            bus.io_rd <= cmd_rd && addr_ok;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_any_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
            rd_ok_reg <= 1'b0;
            rd_ok_wait_reg <= 1'b0;
            cmd_rvalid <= 1'b0;
            cmd_rdata <= BYTE_RESET;
        end else begin
            // refused reads ride the same three-cycle pipe, so back-to-back answers never merge
            rd_any_reg <= cmd_rd;
            rd_wait_reg <= rd_any_reg;
            rd_ok_reg <= cmd_rd && addr_ok;
            rd_ok_wait_reg <= rd_ok_reg;
            cmd_rvalid <= rd_wait_reg;
            cmd_rdata <= rd_ok_wait_reg ? bus.io_rdata : BYTE_RESET;
        end
    end

    // vector execution clears its flag in the device
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus.global_irq_en <= 1'b0;
            bus.irq_ack <= IRQ_RESET;
            irq_pending <= IRQ_RESET;
        end else begin
            bus.global_irq_en <= global_irq_en;
            bus.irq_ack <= vector_ack;
            irq_pending <= bus.irq_req;
        end
    end

endmodule : timer_cpu_end

// >>> dv/timer16_cc_checker.sv
// interface assertions for the timer capture/compare register ends
// assumes instantiation beside the timer_io_if that joins both ends
`timescale 1ns/100ps
module timer16_cc_checker
    import timer_cc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // i/o bus
    input wire logic [IO_ADDR_W-1:0] io_addr,
    input wire logic [DATA_W-1:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [DATA_W-1:0] io_rdata,
    // interrupt lines
    input wire logic global_irq_en,
    input wire logic [IRQ_NUM-1:0] irq_req,
    input wire logic [IRQ_NUM-1:0] irq_ack
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire en_wr = io_wr && (io_addr == IRQ_ENABLES_OFS);

    a_cap_req_gate: assert property (!global_irq_en |=> !irq_req[3])
        else $error("capture request without global enable");
    a_cmpa_req_gate: assert property (en_wr && !io_wdata[COMPARE_A_BIT] |=> ##1 !irq_req[2])
        else $error("compare a request after enable cleared");
    a_cmpb_req_gate: assert property (en_wr && !io_wdata[COMPARE_B_BIT] |=> ##1 !irq_req[1])
        else $error("compare b request after enable cleared");
    a_ovf_req_gate: assert property ($fell(global_irq_en) |=> !irq_req[0])
        else $error("overflow request after global disable");
    a_req_needs_global: assert property (irq_req != 4'h0 |-> $past(global_irq_en))
        else $error("request raised while global enable low");
    a_strobe_excl: assert property (!(io_wr && io_rd))
        else $error("read and write strobes together");
    a_rdata_holds: assert property (!io_rd |=> $stable(io_rdata))
        else $error("read data changed without a read");
    a_spare_bits_zero: assert property (io_rd && (io_addr == IRQ_FLAGS_OFS || io_addr == IRQ_ENABLES_OFS)
        |=> (io_rdata & 8'hC3) == 8'h00)
        else $error("unused flag or enable bits read as one");

    // main scenarios reached
    c_wr_rd: cover property (io_wr ##2 io_rd);
    c_cap_req: cover property ($rose(irq_req[3]));
    c_ack: cover property (irq_ack != 4'h0);
    c_cmpb_drop: cover property ($fell(irq_req[1]));
endmodule : timer16_cc_checker

// >>> dv/timer16_capture_compare_irq_test.sv
// self-checking bench: cpu end and register end joined by timer_io_if
// assumes the hdl/ package, interface and modules are compiled first
`timescale 1ns/100ps
module timer16_capture_compare_irq_test;
    import timer_cc_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [6:0] cmd_addr = '0;
    logic cmd_data_space = 1'b0;
    logic [7:0] cmd_wdata = '0;
    logic cmd_wr = 1'b0;
    logic cmd_rd = 1'b0;
    logic [7:0] cmd_rdata;
    logic cmd_rvalid;
    logic global_irq_en = 1'b0;
    logic [3:0] vector_ack = '0;
    logic [3:0] irq_pending;
    logic [15:0] counter_value = '0;
    logic [15:0] compare_a_value = '0;
    logic timer_tick = 1'b0;
    logic top_reached = 1'b0;
    logic overflow_event = 1'b0;
    logic [3:0] waveform_mode_sel = '0;
    logic force_compare_b = 1'b0;
    logic capture_rising = 1'b1;
    logic capture_from_comp = 1'b0;
    logic capture_pin = 1'b0;
    logic analog_comp_out = 1'b0;
    logic [15:0] capture_value;
    logic [15:0] compare_b_value;
    logic [7:0] shared_temp;
    logic compare_b_event;
    logic capture_is_top;
    logic [7:0] exp_q[$];
    logic [5:0] offs[6] = '{CAPTURE_LOW_OFS, CAPTURE_HIGH_OFS, COMPARE_B_LOW_OFS, COMPARE_B_HIGH_OFS,
        IRQ_FLAGS_OFS, IRQ_ENABLES_OFS};
    logic [3:0] tops[4] = '{MODE_PFC_CAPTURE_TOP, MODE_PC_CAPTURE_TOP, MODE_CTC_CAPTURE_TOP, MODE_FAST_CAPTURE_TOP};
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [15:0] v;
    logic [15:0] c;

    timer_io_if io_bus ();
    timer_capture_compare timer_capture_compare_inst (.core_clk(core_clk), .rst_b(rst_b), .bus(io_bus),
        .counter_value(counter_value), .compare_a_value(compare_a_value), .timer_tick(timer_tick),
        .top_reached(top_reached), .overflow_event(overflow_event), .waveform_mode_sel(waveform_mode_sel),
        .force_compare_b(force_compare_b), .capture_rising(capture_rising), .capture_from_comp(capture_from_comp),
        .capture_pin(capture_pin), .analog_comp_out(analog_comp_out), .capture_value(capture_value),
        .compare_b_value(compare_b_value), .shared_temp(shared_temp), .compare_b_event(compare_b_event),
        .capture_is_top(capture_is_top));
    timer_cpu_end timer_cpu_end_inst (.core_clk(core_clk), .rst_b(rst_b), .bus(io_bus), .cmd_addr(cmd_addr),
        .cmd_data_space(cmd_data_space), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .global_irq_en(global_irq_en),
        .vector_ack(vector_ack), .irq_pending(irq_pending));
    timer16_cc_checker timer16_cc_checker_inst (.core_clk(core_clk), .rst_b(rst_b), .io_addr(io_bus.io_addr),
        .io_wdata(io_bus.io_wdata), .io_wr(io_bus.io_wr), .io_rd(io_bus.io_rd), .io_rdata(io_bus.io_rdata),
        .global_irq_en(io_bus.global_irq_en), .irq_req(io_bus.irq_req), .irq_ack(io_bus.irq_ack));

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val

    // one idle cycle between commands keeps each strobe a single assignment per step
    task automatic bus(input logic [6:0] a, input logic ds, input logic w, input logic [7:0] d);
        @(posedge core_clk);
        cmd_addr <= a;
        cmd_data_space <= ds;
        cmd_wdata <= d;
        cmd_wr <= w;
        cmd_rd <= !w;
        @(posedge core_clk);
        cmd_wr <= 1'b0;
        cmd_rd <= 1'b0;
    endtask : bus

    function automatic logic [6:0] adr(input logic ds, input logic [5:0] ofs);
        return ds ? {1'b0, ofs} + DATA_SPACE_BASE : {1'b0, ofs};
    endfunction : adr

    task automatic rd_raw(input logic [6:0] a, input logic ds, input logic [7:0] e);
        exp_q.push_back(e);
        bus(a, ds, 1'b0, 8'h00);
    endtask : rd_raw

    task automatic rd(input logic ds, input logic [5:0] ofs, input logic [7:0] e);
        rd_raw(adr(ds, ofs), ds, e);
    endtask : rd

    task automatic wr(input logic ds, input logic [5:0] ofs, input logic [7:0] d);
        bus(adr(ds, ofs), ds, 1'b1, d);
    endtask : wr

    task automatic wait_n(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_n

    task automatic strobe(input int k);
        @(posedge core_clk);
        case (k)
            0: timer_tick <= 1'b1;
            1: overflow_event <= 1'b1;
            default: force_compare_b <= 1'b1;
        endcase
        @(posedge core_clk);
        timer_tick <= 1'b0;
        overflow_event <= 1'b0;
        force_compare_b <= 1'b0;
    endtask : strobe

    task automatic ack(input int i);
        @(posedge core_clk);
        vector_ack <= 4'h1 << i;
        @(posedge core_clk);
        vector_ack <= 4'h0;
    endtask : ack

    task automatic pend(input logic [3:0] e);
        wait_n(3);
        check_val("irq_pending", {12'h000, e}, {12'h000, irq_pending});
    endtask : pend

    always @(posedge core_clk) begin
        cycles++;
        if (rst_b && cmd_rvalid === 1'b1) begin
            if (exp_q.size() == 0) check_val("cmd_rvalid", 16'h0000, 16'h0001);
            else check_val("cmd_rdata", {8'h00, exp_q.pop_front()}, {8'h00, cmd_rdata});
        end
        if (cycles > 20000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        void'($urandom(14));
        v = 16'($urandom());
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        compare_a_value <= ~v;
        foreach (offs[i]) rd(1'b0, offs[i], 8'h00);
        wr(1'b1, COMPARE_B_HIGH_OFS, v[15:8]);
        wr(1'b1, COMPARE_B_LOW_OFS, v[7:0]);
        wait_n(2);
        check_val("compare_b_value", v, compare_b_value);
        rd(1'b0, COMPARE_B_HIGH_OFS, v[15:8]);
        rd(1'b0, COMPARE_B_LOW_OFS, v[7:0]);
        wr(1'b0, IRQ_ENABLES_OFS, 8'hFF);
        rd(1'b1, IRQ_ENABLES_OFS, 8'h3C);
        global_irq_en <= 1'b1;
        counter_value <= v + 16'h0001;
        strobe(0);
        #1 check_val("compare_b_event", 16'h0000, {15'h0000, compare_b_event});
        strobe(2);
        #1 check_val("compare_b_event", 16'h0001, {15'h0000, compare_b_event});
        wait_n(3);
        rd(1'b0, IRQ_FLAGS_OFS, 8'h00);
        counter_value <= v;
        strobe(0);
        #1 check_val("compare_b_event", 16'h0001, {15'h0000, compare_b_event});
        pend(4'h2);
        rd(1'b0, IRQ_FLAGS_OFS, 8'h08);
        wr(1'b0, IRQ_FLAGS_OFS, 8'h00);
        rd(1'b0, IRQ_FLAGS_OFS, 8'h08);
        compare_a_value <= v;
        strobe(0);
        pend(4'h6);
        rd(1'b1, IRQ_FLAGS_OFS, 8'h18);
        wr(1'b0, IRQ_ENABLES_OFS, 8'h24);
        pend(4'h0);
        wr(1'b0, IRQ_ENABLES_OFS, 8'h3C);
        pend(4'h6);
        ack(2);
        rd(1'b0, IRQ_FLAGS_OFS, 8'h08);
        wr(1'b1, IRQ_FLAGS_OFS, 8'h08);
        rd(1'b0, IRQ_FLAGS_OFS, 8'h00);
        strobe(1);
        pend(4'h1);
        wr(1'b0, IRQ_ENABLES_OFS, 8'h38);
        pend(4'h0);
        wr(1'b0, IRQ_ENABLES_OFS, 8'h3C);
        pend(4'h1);
        global_irq_en <= 1'b0;
        pend(4'h0);
        global_irq_en <= 1'b1;
        wr(1'b0, IRQ_FLAGS_OFS, 8'h04);
        rd(1'b0, IRQ_FLAGS_OFS, 8'h00);
        // pin capture, then comparator capture on a falling edge between the two byte reads
        c = 16'($urandom());
        counter_value <= c;
        capture_pin <= 1'b1;
        wait_n(6);
        check_val("capture_value", c, capture_value);
        pend(4'h8);
        rd(1'b0, IRQ_FLAGS_OFS, 8'h20);
        rd(1'b0, CAPTURE_LOW_OFS, c[7:0]);
        wait_n(1);
        check_val("shared_temp", {8'h00, c[15:8]}, {8'h00, shared_temp});
        // moving to the comparator fakes a falling edge; it captures c again before the real one
        capture_from_comp <= 1'b1;
        capture_rising <= 1'b0;
        analog_comp_out <= 1'b1;
        wait_n(4);
        counter_value <= ~c;
        analog_comp_out <= 1'b0;
        wait_n(6);
        rd(1'b0, CAPTURE_HIGH_OFS, c[15:8]);
        check_val("capture_value", ~c, capture_value);
        wr(1'b0, COMPARE_B_HIGH_OFS, 8'h5A);
        rd(1'b0, CAPTURE_HIGH_OFS, 8'h5A);
        // moving back to the pin fakes a rising edge; let its flag land before the vector clears it
        capture_from_comp <= 1'b0;
        capture_rising <= 1'b1;
        wait_n(4);
        ack(3);
        rd(1'b0, IRQ_FLAGS_OFS, 8'h00);
        counter_value <= ~v;
        foreach (tops[i]) begin
            waveform_mode_sel <= tops[i];
            capture_pin <= 1'b0;
            wait_n(4);
            capture_pin <= 1'b1;
            wait_n(6);
            check_val("capture_is_top", 16'h0001, {15'h0000, capture_is_top});
            rd(1'b0, IRQ_FLAGS_OFS, 8'h00);
            top_reached <= 1'b1;
            strobe(0);
            top_reached <= 1'b0;
            wait_n(3);
            rd(1'b0, IRQ_FLAGS_OFS, 8'h20);
            wr(1'b0, IRQ_FLAGS_OFS, 8'h20);
        end
        waveform_mode_sel <= 4'h0;
        wait_n(3);
        check_val("capture_is_top", 16'h0000, {15'h0000, capture_is_top});
        rd_raw(7'h60, 1'b1, 8'h00);
        rd_raw(7'h10, 1'b1, 8'h00);
        wr(1'b0, 6'h10, 8'hFF);
        bus(7'h79, 1'b0, 1'b1, 8'h00);
        rd(1'b0, IRQ_ENABLES_OFS, 8'h3C);
        rd(1'b0, 6'h10, 8'h00);
        wait_n(6);
        check_val("pending_reads", 16'h0000, 16'(exp_q.size()));
        summarize();
    end
endmodule : timer16_capture_compare_irq_test
